// ### shared/nvs_pkg.sv
package nvs_pkg;

  // array geometry
  localparam int unsigned NVS_ADDR_W     = 15;
  localparam int unsigned NVS_DATA_W     = 8;
  localparam int unsigned NVS_MEM_DEPTH  = 32768;
  localparam int unsigned NVS_FIFO_DEPTH = 32;

  // device address word layout
  localparam int unsigned NVS_TYPE_MSB   = 7;
  localparam int unsigned NVS_TYPE_LSB   = 4;
  localparam int unsigned NVS_STRAP_MSB  = 3;
  localparam int unsigned NVS_STRAP_LSB  = 1;
  localparam int unsigned NVS_RW_BIT     = 0;
  localparam int unsigned NVS_HI_MSB     = 6;

  // type code value is arbitrary, chosen for this block
  localparam logic [3:0] NVS_TYPE_CODE_DFLT = 4'h5;

  // bit counter marks within one byte slot
  localparam logic [3:0] NVS_CNT_ZERO = 4'h0;
  localparam logic [3:0] NVS_CNT_BYTE = 4'h8;
  localparam logic [3:0] NVS_CNT_ACK  = 4'h9;

  // synchroniser lanes
  localparam int unsigned NVS_SYNC_W      = 6;
  localparam int unsigned NVS_SI_SCL      = 0;
  localparam int unsigned NVS_SI_SDA      = 1;
  localparam int unsigned NVS_SI_GUARD    = 2;
  localparam int unsigned NVS_SI_STRAP_LO = 3;
  localparam int unsigned NVS_SI_STRAP_HI = 5;

  // reset values
  localparam logic [NVS_ADDR_W-1:0] NVS_ADDR_RST = 15'h0000;
  localparam logic [NVS_ADDR_W-1:0] NVS_ADDR_ONE = 15'h0001;
  localparam logic [NVS_SYNC_W-1:0] NVS_SYNC_RST = 6'h03;

  typedef enum logic [2:0] {
    NVS_IDLE,
    NVS_DEV,
    NVS_AHI,
    NVS_ALO,
    NVS_WDAT,
    NVS_RDAT,
    NVS_WAIT
  } nvs_state_t;

  // one write destined for the array
  typedef struct packed {
    logic [NVS_ADDR_W-1:0] addr;
    logic [NVS_DATA_W-1:0] data;
  } nvs_wr_t;

endpackage

// ### hw/nvs_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module nvs_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // fill side
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  // drain side
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  // fill level
  output logic [$clog2(DEPTH):0]      level
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [W-1:0]  store_r [DEPTH];
  logic [PW:0]   wr_ptr_r;
  logic [PW:0]   rd_ptr_r;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;
  wire           full;
  wire           empty;

  // extra pointer bit tells full from empty
  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign full      = (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]) & (wr_ptr_r[PW] != rd_ptr_r[PW]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = store_r[rd_ptr_r[PW-1:0]];
  assign level     = wr_ptr_r - rd_ptr_r;

  always_ff @(posedge clk) begin
    if (push) begin
      store_r[wr_ptr_r[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule // nvs_fifo
`default_nettype wire

// ### hw/nvs_array.sv
`timescale 1ns/1ps
`default_nettype none
module nvs_array #(
  parameter int unsigned AW    = 15,
  parameter int unsigned DW    = 8,
  parameter int unsigned DEPTH = 32768
) (
  // clock
  input  wire logic          clk,
  // single shared port
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] cell_r [DEPTH];

  // read data held until the next read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      cell_r[addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= cell_r[addr];
    end
  end
endmodule // nvs_array
`default_nettype wire

// ### hw/nvs_slave.sv
`timescale 1ns/1ps
`default_nettype none
module nvs_slave
  import nvs_pkg::*;
#(
  parameter logic [3:0]  TYPE_CODE  = nvs_pkg::NVS_TYPE_CODE_DFLT,
  parameter int unsigned FIFO_DEPTH = nvs_pkg::NVS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                            CLOCK,
  input  wire logic                            RSTN,
  // two-wire link
  input  wire logic                            SCL,
  input  wire logic                            SDA_I,
  output logic                                 SDA_O,
  output logic                                 SDA_OE_N,
  // straps and guard
  input  wire logic [2:0]                      ADDRESS_STRAP_PINS,
  input  wire logic                            WRITE_GUARD,
  // array commit stall
  input  wire logic                            ARRAY_HOLD,
  // status
  output logic                                 BUSY,
  output logic                                 READ_DIR,
  output logic [nvs_pkg::NVS_ADDR_W-1:0]       CUR_ADDR,
  output logic [$clog2(FIFO_DEPTH):0]          PENDING_WRITES
);
  import nvs_pkg::*;

  // pin synchronisers
  logic [NVS_SYNC_W-1:0] sync1_r;
  logic [NVS_SYNC_W-1:0] sync2_r;
  logic                  scl_d_r;
  logic                  sda_d_r;

  // protocol state
  nvs_state_t            state_r;
  nvs_state_t            state_nxt;
  logic [3:0]            cnt_r;
  logic [3:0]            cnt_nxt;
  logic [7:0]            rx_r;
  logic [7:0]            rx_nxt;
  logic [7:0]            tx_r;
  logic [7:0]            tx_nxt;
  logic [NVS_ADDR_W-1:0] addr_r;
  logic [NVS_ADDR_W-1:0] addr_nxt;
  logic [6:0]            hi_r;
  logic [6:0]            hi_nxt;
  logic                  rw_r;
  logic                  rw_nxt;
  logic                  drive_r;
  logic                  drive_nxt;
  logic                  ackok_r;
  logic                  ackok_nxt;
  logic                  fetch_r;
  logic                  fetch_nxt;

  // array and queue links
  nvs_wr_t               wr_in;
  nvs_wr_t               wr_out;
  logic                  q_in_ready;
  logic                  q_out_valid;
  logic                  q_out_ready;
  logic [7:0]            mem_q;

  // decoded conditions
  wire scl_s      = sync2_r[NVS_SI_SCL];
  wire sda_s      = sync2_r[NVS_SI_SDA];
  wire guard_s    = sync2_r[NVS_SI_GUARD];
  wire [2:0] strap_s = sync2_r[NVS_SI_STRAP_HI:NVS_SI_STRAP_LO];
  wire scl_rise   = scl_s & ~scl_d_r;
  wire scl_fall   = ~scl_s & scl_d_r;
  wire start_det  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire active     = (state_r != NVS_IDLE) & (state_r != NVS_WAIT);
  wire at_byte    = (cnt_r == NVS_CNT_BYTE);
  wire at_ack     = (cnt_r == NVS_CNT_ACK);
  wire type_hit   = (rx_r[NVS_TYPE_MSB:NVS_TYPE_LSB] == TYPE_CODE);
  wire strap_hit  = (rx_r[NVS_STRAP_MSB:NVS_STRAP_LSB] == strap_s);
  wire dev_hit    = type_hit & strap_hit;
  wire rd_req     = rx_r[NVS_RW_BIT];
  wire wdat_end   = scl_fall & at_ack & (state_r == NVS_WDAT) & ackok_r;
  wire commit     = wdat_end & ~guard_s;
  wire wr_room    = q_in_ready | guard_s;
  // array reads wait for queued writes; bytes shifted out before the fetch lands carry the old mem_q
  wire fetch_go   = fetch_r & ~q_out_valid & ~ARRAY_HOLD;

  // sda and guard rest high and low when idle; straps are pulled low
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_r <= NVS_SYNC_RST;
      sync2_r <= NVS_SYNC_RST;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      sync1_r <= {ADDRESS_STRAP_PINS, WRITE_GUARD, SDA_I, SCL};
      sync2_r <= sync1_r;
      scl_d_r <= sync2_r[NVS_SI_SCL];
      sda_d_r <= sync2_r[NVS_SI_SDA];
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    rx_nxt    = rx_r;
    tx_nxt    = tx_r;
    addr_nxt  = addr_r;
    hi_nxt    = hi_r;
    rw_nxt    = rw_r;
    drive_nxt = drive_r;
    ackok_nxt = ackok_r;
    fetch_nxt = fetch_r;
    if (fetch_go) begin
      fetch_nxt = 1'b0;
      addr_nxt  = addr_r + NVS_ADDR_ONE;
    end
    if (wdat_end) begin
      addr_nxt = addr_r + NVS_ADDR_ONE;
    end
    if (stop_det) begin
      state_nxt = NVS_IDLE;
      cnt_nxt   = NVS_CNT_ZERO;
      drive_nxt = 1'b0;
      fetch_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = NVS_DEV;
      cnt_nxt   = NVS_CNT_ZERO;
      drive_nxt = 1'b0;
      fetch_nxt = 1'b0;
    end else if (scl_rise && active) begin
      cnt_nxt = cnt_r + 4'h1;
      if (!at_byte) begin
        rx_nxt = {rx_r[6:0], sda_s};
      end else if (state_r == NVS_RDAT) begin
        ackok_nxt = ~sda_s;
        fetch_nxt = ~sda_s;
      end
    end else if (scl_fall && active) begin
      if (at_byte) begin
        unique case (state_r)
          NVS_DEV: begin
            if (dev_hit) begin
              drive_nxt = 1'b1;
              rw_nxt    = rd_req;
              fetch_nxt = rd_req;
            end else begin
              state_nxt = NVS_IDLE;
              drive_nxt = 1'b0;
            end
          end
          NVS_AHI: begin
            hi_nxt    = rx_r[NVS_HI_MSB:0];
            drive_nxt = 1'b1;
          end
          NVS_ALO: begin
            addr_nxt  = {hi_r, rx_r};
            drive_nxt = 1'b1;
          end
          NVS_WDAT: begin
            ackok_nxt = wr_room;
            drive_nxt = wr_room;
          end
          NVS_RDAT: begin
            drive_nxt = 1'b0;
          end
          default: begin
            drive_nxt = 1'b0;
          end
        endcase
      end else if (at_ack) begin
        cnt_nxt = NVS_CNT_ZERO;
        unique case (state_r)
          NVS_DEV: begin
            if (rw_r) begin
              state_nxt = NVS_RDAT;
              tx_nxt    = {mem_q[6:0], 1'b0};
              drive_nxt = ~mem_q[7];
            end else begin
              state_nxt = NVS_AHI;
              drive_nxt = 1'b0;
            end
          end
          NVS_AHI: begin
            state_nxt = NVS_ALO;
            drive_nxt = 1'b0;
          end
          NVS_ALO: begin
            state_nxt = NVS_WDAT;
            drive_nxt = 1'b0;
          end
          NVS_WDAT: begin
            drive_nxt = 1'b0;
            if (!ackok_r) begin
              state_nxt = NVS_WAIT;
            end
          end
          NVS_RDAT: begin
            if (ackok_r) begin
              tx_nxt    = {mem_q[6:0], 1'b0};
              drive_nxt = ~mem_q[7];
            end else begin
              state_nxt = NVS_WAIT;
              drive_nxt = 1'b0;
            end
          end
          default: begin
            drive_nxt = 1'b0;
          end
        endcase
      end else if (state_r == NVS_RDAT) begin
        tx_nxt    = {tx_r[6:0], 1'b0};
        drive_nxt = ~tx_r[7];
      end
    end
  end

  // line released and idle from reset on; address is simply zeroed
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= NVS_IDLE;
      cnt_r   <= NVS_CNT_ZERO;
      drive_r <= 1'b0;
      fetch_r <= 1'b0;
      ackok_r <= 1'b0;
      rw_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      drive_r <= drive_nxt;
      fetch_r <= fetch_nxt;
      ackok_r <= ackok_nxt;
      rw_r    <= rw_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rx_r   <= 8'h00;
      tx_r   <= 8'h00;
      hi_r   <= 7'h00;
      addr_r <= NVS_ADDR_RST;
    end else begin
      rx_r   <= rx_nxt;
      tx_r   <= tx_nxt;
      hi_r   <= hi_nxt;
      addr_r <= addr_nxt;
    end
  end

  // queued commits; a held array backs up into not-acknowledge
  assign wr_in.addr  = addr_r;
  assign wr_in.data  = rx_r;
  assign q_out_ready = ~ARRAY_HOLD;

  nvs_fifo #(
    .W     ($bits(nvs_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .clk       (CLOCK),
    .rst_n     (RSTN),
    .in_valid  (commit),
    .in_ready  (q_in_ready),
    .in_data   (wr_in),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (wr_out),
    .level     (PENDING_WRITES)
  );

  wire                  arr_wr   = q_out_valid & q_out_ready;
  wire [NVS_ADDR_W-1:0] arr_addr = fetch_go ? addr_r : wr_out.addr;

  nvs_array #(
    .AW    (NVS_ADDR_W),
    .DW    (NVS_DATA_W),
    .DEPTH (NVS_MEM_DEPTH)
  ) u_array (
    .clk     (CLOCK),
    .wr_en   (arr_wr),
    .rd_en   (fetch_go),
    .addr    (arr_addr),
    .wr_data (wr_out.data),
    .rd_data (mem_q)
  );

  // open drain: only ever pulls low
  assign SDA_O    = 1'b0;
  assign SDA_OE_N = ~drive_r;
  assign BUSY     = (state_r != NVS_IDLE);
  assign READ_DIR = rw_r;
  assign CUR_ADDR = addr_r;
endmodule // nvs_slave
`default_nettype wire

// ### tb/nvs_slave_props.sv
`timescale 1ns/1ps
`default_nettype none
module nvs_slave_props #(
  parameter int unsigned FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic                            CLOCK,
  input wire logic                            RSTN,
  // two-wire link
  input wire logic                            SCL,
  input wire logic                            SDA_I,
  input wire logic                            SDA_O,
  input wire logic                            SDA_OE_N,
  // straps, guard and stall
  input wire logic [2:0]                      ADDRESS_STRAP_PINS,
  input wire logic                            WRITE_GUARD,
  input wire logic                            ARRAY_HOLD,
  // status
  input wire logic                            BUSY,
  input wire logic                            READ_DIR,
  input wire logic [nvs_pkg::NVS_ADDR_W-1:0]  CUR_ADDR,
  input wire logic [$clog2(FIFO_DEPTH):0]     PENDING_WRITES
);
  import nvs_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  chk_sda_never_high:
    assert property (SDA_O == 1'b0)
    else $error("data line driven high");
  // synchroniser delay means the pin has been low two samples back
  chk_oe_scl_low:
    assert property ($changed(SDA_OE_N) |-> !SCL && !$past(SCL, 2))
    else $error("data drive changed while clock high");
  chk_idle_released:
    assert property (!BUSY |-> SDA_OE_N)
    else $error("data line held while idle");
  chk_stop_to_idle:
    assert property (SCL && $past(SCL) && $rose(SDA_I) |-> ##[1:12] !BUSY)
    else $error("stop did not end the transfer");
  chk_guard_no_push:
    assert property (WRITE_GUARD && $past(WRITE_GUARD, 4) |->
                     PENDING_WRITES <= $past(PENDING_WRITES))
    else $error("write queued while guarded");
  chk_hold_stalls:
    assert property ($past(ARRAY_HOLD) && $past(ARRAY_HOLD, 2) |->
                     PENDING_WRITES >= $past(PENDING_WRITES))
    else $error("commit while array held");
  chk_commit_prompt:
    assert property ($rose(PENDING_WRITES != 0) && !ARRAY_HOLD |-> ##[1:16] PENDING_WRITES == 0)
    else $error("write not committed promptly");
  chk_read_addr_step:
    assert property (READ_DIR && $past(READ_DIR) && $changed(CUR_ADDR) |->
                     CUR_ADDR == $past(CUR_ADDR) + 15'h0001)
    else $error("read address did not step by one");
  chk_dir_on_match:
    assert property ($changed(READ_DIR) |-> BUSY)
    else $error("direction changed outside a transfer");
endmodule // nvs_slave_props

bind nvs_slave nvs_slave_props #(.FIFO_DEPTH (FIFO_DEPTH)) chk_u (
  .CLOCK (CLOCK), .RSTN (RSTN), .SCL (SCL), .SDA_I (SDA_I), .SDA_O (SDA_O),
  .SDA_OE_N (SDA_OE_N), .ADDRESS_STRAP_PINS (ADDRESS_STRAP_PINS),
  .WRITE_GUARD (WRITE_GUARD), .ARRAY_HOLD (ARRAY_HOLD), .BUSY (BUSY),
  .READ_DIR (READ_DIR), .CUR_ADDR (CUR_ADDR), .PENDING_WRITES (PENDING_WRITES)
);
`default_nettype wire

// ### tb/nvs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvs_master_model (
  // pacing clock
  input  wire logic clk,
  // bus lines, data is open drain
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // quarter of a 160 ns bus period
  task automatic qtr;
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic start;
    sda_low = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    sda_low = 1'b1;
    qtr();
    scl = 1'b0;
  endtask
  task automatic stop;
    qtr();
    sda_low = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_low = 1'b0;
    qtr();
  endtask
  // data moves mid low phase, sampled mid high phase
  task automatic xfer_bit(input logic b, output logic s);
    qtr();
    sda_low = ~b;
    qtr();
    scl = 1'b1;
    qtr();
    s = sda;
    qtr();
    scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], s);
    end
    xfer_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, s);
      d[i] = s;
    end
    xfer_bit(~ack, s);
  endtask
endmodule // nvs_master_model
`default_nettype wire

// ### tb/tb_nvs_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tb_nvs_slave;
  import nvs_pkg::*;
  logic                            CLOCK, RSTN, SCL, SDA_O, SDA_OE_N, BUSY, READ_DIR;
  logic                            WRITE_GUARD, ARRAY_HOLD, sda_low, sda_w, ack_v;
  logic [2:0]                      strap_v;
  logic [NVS_ADDR_W-1:0]           CUR_ADDR;
  logic [$clog2(NVS_FIFO_DEPTH):0] PENDING_WRITES;
  logic [7:0]                      rd_v;
  logic [7:0]                      mem_exp [int];
  int                              error_cnt, cmp_count;

  // pull-up wins unless someone pulls low
  assign sda_w = !sda_low && (SDA_OE_N || SDA_O);
  always #2 CLOCK = ~CLOCK;

  nvs_slave dut_u (
    .CLOCK (CLOCK), .RSTN (RSTN), .SCL (SCL), .SDA_I (sda_w), .SDA_O (SDA_O),
    .SDA_OE_N (SDA_OE_N), .ADDRESS_STRAP_PINS (strap_v), .WRITE_GUARD (WRITE_GUARD),
    .ARRAY_HOLD (ARRAY_HOLD), .BUSY (BUSY), .READ_DIR (READ_DIR), .CUR_ADDR (CUR_ADDR),
    .PENDING_WRITES (PENDING_WRITES)
  );
  nvs_master_model mst_u (.clk (CLOCK), .scl (SCL), .sda_low (sda_low), .sda (sda_w));

  function automatic logic [7:0] dev_word(input logic [3:0] t, input logic [2:0] s,
                                          input logic rw);
    return {t, s, rw};
  endfunction
  function automatic logic [NVS_ADDR_W-1:0] nxt(input logic [NVS_ADDR_W-1:0] a);
    return a + 15'h0001;
  endfunction
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wait_idle;
    int t;
    t = 0;
    while (PENDING_WRITES !== '0 && t < 1000) begin
      @(posedge CLOCK);
      t++;
    end
    #1;
    check("drain", 32'h0, 32'(PENDING_WRITES));
    if (t >= 1000) complete_run();
  endtask
  task automatic set_addr(input logic [NVS_ADDR_W-1:0] a);
    mst_u.start();
    mst_u.send_byte(dev_word(NVS_TYPE_CODE_DFLT, strap_v, 1'b0), ack_v);
    check("word ack", 32'h1, 32'(ack_v));
    mst_u.send_byte({1'b0, a[14:8]}, ack_v);
    check("high ack", 32'h1, 32'(ack_v));
    mst_u.send_byte(a[7:0], ack_v);
    check("low ack", 32'h1, 32'(ack_v));
  endtask
  task automatic write_seq(input logic [NVS_ADDR_W-1:0] a, input int n, input int nack_at);
    logic [7:0] d;
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      mst_u.send_byte(d, ack_v);
      check("data ack", 32'(i != nack_at), 32'(ack_v));
      if (i == nack_at) break;
      if (WRITE_GUARD !== 1'b1) mem_exp[a] = d;
      a = nxt(a);
    end
    mst_u.stop();
    check("write dir", 32'h0, 32'(READ_DIR));
    if (nack_at < 0) check("write addr", 32'(a), 32'(CUR_ADDR));
  endtask
  task automatic read_seq(input logic [NVS_ADDR_W-1:0] a, input int n);
    set_addr(a);
    mst_u.start();
    mst_u.send_byte(dev_word(NVS_TYPE_CODE_DFLT, strap_v, 1'b1), ack_v);
    check("read word ack", 32'h1, 32'(ack_v));
    for (int i = 0; i < n; i++) begin
      mst_u.recv_byte(i < n - 1, rd_v);
      check("read data", 32'(mem_exp[a]), 32'(rd_v));
      a = nxt(a);
    end
    mst_u.stop();
    check("read dir", 32'h1, 32'(READ_DIR));
    check("read addr", 32'(a), 32'(CUR_ADDR));
  endtask
  task automatic bad_word(input logic [7:0] w);
    mst_u.start();
    mst_u.send_byte(w, ack_v);
    check("foreign ack", 32'h0, 32'(ack_v));
    mst_u.send_byte(8'h00, ack_v);
    check("ignored ack", 32'h0, 32'(ack_v));
    check("foreign busy", 32'h0, 32'(BUSY));
    mst_u.stop();
  endtask

  initial begin
    logic [NVS_ADDR_W-1:0] a;
    int n;
    CLOCK = 1'b0;
    RSTN = 1'b0;
    WRITE_GUARD = 1'b0;
    ARRAY_HOLD = 1'b0;
    strap_v = 3'h0;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(32'hafa4));
    repeat (2) @(posedge CLOCK);
    #1;
    RSTN = 1'b1;
    check("reset oe", 32'h1, 32'(SDA_OE_N));
    check("reset busy", 32'h0, 32'(BUSY));
    check("reset pending", 32'h0, 32'(PENDING_WRITES));
    repeat (4) @(posedge CLOCK);
    #1;
    // straps and guard driven low; read follows write stop at once
    a = 15'($urandom);
    write_seq(a, 3, -1);
    read_seq(a, 3);
    strap_v = 3'($urandom);
    bad_word(dev_word(NVS_TYPE_CODE_DFLT ^ 4'h3, strap_v, 1'b0));
    bad_word(dev_word(NVS_TYPE_CODE_DFLT, strap_v ^ 3'h4, 1'b1));
    for (int k = 0; k < 4; k++) begin
      a = 15'($urandom);
      n = 1 + $urandom_range(3);
      write_seq(a, n, -1);
      read_seq(a, n);
    end
    write_seq(15'h7fff, 2, -1);
    read_seq(15'h7fff, 2);
    // guarded bytes are acked but never land
    WRITE_GUARD = 1'b1;
    write_seq(15'h7fff, 2, -1);
    read_seq(15'h7fff, 2);
    WRITE_GUARD = 1'b0;
    set_addr(15'h7fff);
    for (int k = 0; k < 4; k++) begin
      mst_u.xfer_bit(1'b0, ack_v);
    end
    mst_u.stop();
    check("abort busy", 32'h0, 32'(BUSY));
    read_seq(15'h7fff, 1);
    // stalled array: queue fills, next byte refused
    ARRAY_HOLD = 1'b1;
    a = 15'($urandom);
    write_seq(a, NVS_FIFO_DEPTH + 1, NVS_FIFO_DEPTH);
    check("full pending", 32'(NVS_FIFO_DEPTH), 32'(PENDING_WRITES));
    ARRAY_HOLD = 1'b0;
    wait_idle();
    read_seq(a, NVS_FIFO_DEPTH);
    complete_run();
  end
endmodule // tb_nvs_slave
`default_nettype wire
